/* File: hdl/fsl_pkg.sv */
// Constants, types and helpers shared by the flash host controller.
// Behaviour
// - Pulse enables high between successive status reads
// - Never assume first or last toggle level
// - Keep one fixed address through polling
// - Commands: byte data, fifteen-bit command addresses
package fsl_pkg;

  // ----------------------------------------------------------------
  // Widths and address map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 18;
  localparam int DATA_W = 8;
  localparam int CMD_ADDR_BITS = 15;
  localparam int TOGGLE_BIT = 6;
  localparam logic [ADDR_W-1:0] ID_MAKER_ADDR = 18'h00000;
  localparam logic [ADDR_W-1:0] ID_PART_ADDR = 18'h00001;
  localparam logic [ADDR_W-1:0] BOOT_LO_ADDR = 18'h00000;
  localparam logic [ADDR_W-1:0] BOOT_HI_ADDR = 18'h01fff;

  // ----------------------------------------------------------------
  // Timing, in ns as printed (erase time in s), and derived cycle counts
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_ACC_NS = 90;
  localparam int T_WP_NS = 90;
  localparam int T_WPH_NS = 90;
  localparam int T_AH_NS = 50;
  localparam int MIN_ENABLE_HIGH_PULSE_NS = 150;
  localparam longint T_EC_S = 10;

  function automatic int nsToCyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : nsToCyc

  localparam int T_ACC_CYC = nsToCyc(T_ACC_NS) + 1;
  localparam int T_WP_CYC = nsToCyc(T_WP_NS);
  localparam int T_WPH_CYC = nsToCyc(T_WPH_NS);
  localparam int T_AH_CYC = nsToCyc(T_AH_NS);
  localparam int MIN_ENABLE_HIGH_PULSE_CYC = nsToCyc(MIN_ENABLE_HIGH_PULSE_NS);
  localparam longint POLL_LIMIT_DEF = T_EC_S * 1000000000 / CLK_PERIOD_NS;

  localparam int CNT_W = 5;

  // ----------------------------------------------------------------
  // Operation codes of the user port
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_READ  = 3'b000,
    OP_WRITE = 3'b001,
    OP_CMD   = 3'b010,
    OP_POLL  = 3'b011,
    OP_ID    = 3'b100
  } fsl_op_t;

  function automatic logic [ADDR_W-1:0] cmdAddr(input logic [ADDR_W-1:0] a);
    return {{(ADDR_W-CMD_ADDR_BITS){1'b0}}, a[CMD_ADDR_BITS-1:0]};
  endfunction : cmdAddr

  function automatic logic inBootBlock(input logic [ADDR_W-1:0] a);
    return (a >= BOOT_LO_ADDR) && (a <= BOOT_HI_ADDR);
  endfunction : inBootBlock

endpackage : fsl_pkg

/* File: hdl/fsl_cyc_if.sv */
// Carrier between the operation sequencer and the single bus cycle engine.
`timescale 1ns/1ns
interface fsl_cyc_if;
  import fsl_pkg::*;
  logic req;
  logic wr;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic done;
  logic [DATA_W-1:0] rdata;
  modport master (output req, output wr, output addr, output wdata, input done, input rdata);
  modport slave (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface : fsl_cyc_if

/* File: hdl/fsl_cycle.sv */
// One timed read or write cycle on the flash pins.
`timescale 1ns/1ns
module fsl_cycle
  import fsl_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Sequencer side
  fsl_cyc_if.slave cyc,
  // Flash pins
  output logic [ADDR_W-1:0] flashAddr,
  output logic flashCeN,
  output logic flashOeN,
  output logic flashWeN,
  output logic [DATA_W-1:0] flashDout,
  output logic flashDoutEn,
  input wire logic [DATA_W-1:0] flashDin
);

  typedef enum logic [2:0] {
    CY_IDLE  = 3'b000,
    CY_RD    = 3'b001,
    CY_WPULS = 3'b010,
    CY_WHOLD = 3'b011,
    CY_REC   = 3'b100
  } fsl_cy_t;

  fsl_cy_t state_r;
  logic [CNT_W-1:0] cnt_r;
  logic doneR_r;
  logic [DATA_W-1:0] rdata_r;
  logic cntZero;

  assign cntZero = (cnt_r == '0);
  assign cyc.done = doneR_r;
  assign cyc.rdata = rdata_r;

  // ----------------------------------------------------------------
  // Cycle sequence
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= CY_IDLE;
      cnt_r <= '0;
      doneR_r <= 1'b0;
    end
    else
    begin
      doneR_r <= 1'b0;
      if (!cntZero)
        cnt_r <= cnt_r - 1'b1;
      unique case (state_r)
        CY_IDLE:
          if (cyc.req)
          begin
            state_r <= cyc.wr ? CY_WPULS : CY_RD;
            cnt_r <= cyc.wr ? CNT_W'(T_WP_CYC - 1) : CNT_W'(T_ACC_CYC - 1);
          end
        CY_RD:
          if (cntZero)
          begin
            // Enables go high for a full pulse before the next read may start.
            state_r <= CY_REC;
            cnt_r <= CNT_W'(MIN_ENABLE_HIGH_PULSE_CYC - 1);
          end
        CY_WPULS:
          if (cntZero)
          begin
            state_r <= CY_WHOLD;
            cnt_r <= CNT_W'(T_AH_CYC - 1);
          end
        CY_WHOLD:
          if (cntZero)
          begin
            // Hold both address and data past the rising strobe edge.
            state_r <= CY_REC;
            cnt_r <= CNT_W'(T_WPH_CYC - T_AH_CYC - 1);
          end
        CY_REC:
          if (cntZero)
          begin
            state_r <= CY_IDLE;
            doneR_r <= 1'b1;
          end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flashAddr <= '0;
      flashDout <= '0;
      flashDoutEn <= 1'b0;
      flashCeN <= 1'b1;
      flashOeN <= 1'b1;
      flashWeN <= 1'b1;
    end
    else if (state_r == CY_IDLE && cyc.req)
    begin
      flashAddr <= cyc.addr;
      flashDout <= cyc.wdata;
      flashDoutEn <= cyc.wr;
      flashCeN <= 1'b0;
      flashOeN <= cyc.wr;
      flashWeN <= !cyc.wr;
    end
    else if (cntZero && (state_r == CY_RD || state_r == CY_WPULS))
    begin
      flashCeN <= 1'b1;
      flashOeN <= 1'b1;
      flashWeN <= 1'b1;
    end
    else if (cntZero && state_r == CY_WHOLD)
      flashDoutEn <= 1'b0;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      rdata_r <= '0;
    else if (state_r == CY_RD && cntZero)
      rdata_r <= flashDin;
  end

endmodule : fsl_cycle

/* File: hdl/fsl_host.sv */
// Flash host controller: reads, writes, command bytes, toggle polling, identification.
`timescale 1ns/1ns
module fsl_host
  import fsl_pkg::*;
#(
  parameter longint POLL_LIMIT_CYC = POLL_LIMIT_DEF
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // User operation port
  input wire logic opValid,
  input wire logic [2:0] opCode,
  input wire logic [ADDR_W-1:0] opAddr,
  input wire logic [DATA_W-1:0] opData,
  output logic opReady,
  // User result port
  output logic resValid,
  output logic [DATA_W-1:0] resData,
  output logic [DATA_W-1:0] resData2,
  output logic resTimeout,
  output logic resBootHit,
  // Flash pins
  output logic [ADDR_W-1:0] flashAddr,
  output logic flashCeN,
  output logic flashOeN,
  output logic flashWeN,
  output logic [DATA_W-1:0] flashDout,
  output logic flashDoutEn,
  input wire logic [DATA_W-1:0] flashDin
);

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ISSUE = 2'b01,
    ST_WAIT  = 2'b10
  } fsl_st_t;

  fsl_cyc_if cyc ();

  fsl_st_t state_r;
  fsl_op_t op_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] data_r;
  logic firstRead_r;
  logic lastToggle_r;
  logic [63:0] pollCnt_r;
  logic finish;
  logic pollOver;
  logic newToggle;

  fsl_cycle u_cycle (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .cyc(cyc.slave),
    .flashAddr(flashAddr),
    .flashCeN(flashCeN),
    .flashOeN(flashOeN),
    .flashWeN(flashWeN),
    .flashDout(flashDout),
    .flashDoutEn(flashDoutEn),
    .flashDin(flashDin)
  );

  assign opReady = (state_r == ST_IDLE);
  assign newToggle = cyc.rdata[TOGGLE_BIT];
  assign pollOver = (pollCnt_r >= 64'(POLL_LIMIT_CYC));

  // ----------------------------------------------------------------
  // Completion decision after each bus cycle
  // ----------------------------------------------------------------
  always_comb
  begin
    finish = 1'b0;
    if (state_r == ST_WAIT && cyc.done)
    begin
      unique case (op_r)
        OP_ID:
          finish = !firstRead_r;
        // Only a repeat of the previous level counts; no level is assumed.
        OP_POLL:
          finish = (!firstRead_r && newToggle == lastToggle_r) || pollOver;
        default:
          finish = 1'b1;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= ST_IDLE;
      op_r <= OP_READ;
      addr_r <= '0;
      data_r <= '0;
      firstRead_r <= 1'b1;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE:
          if (opValid)
          begin
            op_r <= fsl_op_t'(opCode);
            data_r <= opData;
            firstRead_r <= 1'b1;
            state_r <= ST_ISSUE;
            if (fsl_op_t'(opCode) == OP_CMD)
              addr_r <= cmdAddr(opAddr);
            else if (fsl_op_t'(opCode) == OP_ID)
              addr_r <= ID_MAKER_ADDR;
            else
              addr_r <= opAddr;
          end
        ST_ISSUE:
          state_r <= ST_WAIT;
        ST_WAIT:
          if (cyc.done)
          begin
            firstRead_r <= 1'b0;
            if (finish)
              state_r <= ST_IDLE;
            else
            begin
              state_r <= ST_ISSUE;
              // The poll address never changes; only identification steps on.
              if (op_r == OP_ID)
                addr_r <= ID_PART_ADDR;
            end
          end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  assign cyc.req = (state_r == ST_ISSUE);
  assign cyc.wr = (op_r == OP_WRITE) || (op_r == OP_CMD);
  assign cyc.addr = addr_r;
  assign cyc.wdata = data_r;

  // ----------------------------------------------------------------
  // Toggle history and poll time limit
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      lastToggle_r <= 1'b0;
    else if (state_r == ST_WAIT && cyc.done)
      lastToggle_r <= newToggle;
  end

  // An erase can run for seconds, so the limit is a parameter to shorten in simulation.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      pollCnt_r <= '0;
    else if (state_r == ST_IDLE)
      pollCnt_r <= '0;
    else if (!pollOver)
      pollCnt_r <= pollCnt_r + 64'h1;
  end

  // ----------------------------------------------------------------
  // Results
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      resValid <= 1'b0;
      resData <= '0;
      resData2 <= '0;
      resTimeout <= 1'b0;
      resBootHit <= 1'b0;
    end
    else
    begin
      resValid <= finish;
      if (state_r == ST_WAIT && cyc.done)
      begin
        if (op_r == OP_ID && firstRead_r)
          resData <= cyc.rdata;
        else if (op_r == OP_ID)
          resData2 <= cyc.rdata;
        else
          resData <= cyc.rdata;
      end
      if (finish)
      begin
        resTimeout <= (op_r == OP_POLL) && pollOver && !(!firstRead_r && newToggle == lastToggle_r);
        resBootHit <= (op_r == OP_WRITE) && inBootBlock(addr_r);
      end
    end
  end

endmodule : fsl_host

/* File: verification/fsl_host_assertions.sv */
// Checker for the flash host controller pins and result port.
`timescale 1ns/1ns
module fsl_host_assertions
  import fsl_pkg::*;
#(
  parameter longint POLL_LIMIT_CYC = POLL_LIMIT_DEF
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // User side
  input wire logic opValid,
  input wire logic opReady,
  input wire logic [2:0] opCode,
  input wire logic [ADDR_W-1:0] opAddr,
  input wire logic [DATA_W-1:0] opData,
  input wire logic resValid,
  input wire logic [DATA_W-1:0] resData,
  input wire logic resTimeout,
  // Flash pins
  input wire logic [ADDR_W-1:0] flashAddr,
  input wire logic flashOeN,
  input wire logic flashWeN,
  input wire logic [DATA_W-1:0] flashDout,
  input wire logic flashDoutEn,
  input wire logic [DATA_W-1:0] flashDin
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic take, rdEnd, pollAct_r, cmdAct_r, oeHi_r, togNow_r, togLast_r, togPrev_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] data_r;
  logic [3:0] rdCnt_r;
  assign take = opValid && opReady;
  assign rdEnd = flashOeN && !oeHi_r;

  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      pollAct_r <= 1'b0;
      cmdAct_r <= 1'b0;
      addr_r <= '0;
      data_r <= '0;
    end
    else if (take)
    begin
      pollAct_r <= opCode == OP_POLL;
      cmdAct_r <= opCode == OP_CMD;
      addr_r <= opAddr;
      data_r <= opData;
    end
    else if (resValid)
    begin
      pollAct_r <= 1'b0;
      cmdAct_r <= 1'b0;
    end

  // Toggle levels of the last two completed reads, as the bus showed them.
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      oeHi_r <= 1'b1;
      togNow_r <= 1'b0;
      togLast_r <= 1'b0;
      togPrev_r <= 1'b0;
      rdCnt_r <= '0;
    end
    else
    begin
      oeHi_r <= flashOeN;
      if (!flashOeN)
        togNow_r <= flashDin[TOGGLE_BIT];
      if (rdEnd)
      begin
        togLast_r <= togNow_r;
        togPrev_r <= togLast_r;
      end
      if (take)
        rdCnt_r <= '0;
      else if (rdEnd && rdCnt_r != 4'hf)
        rdCnt_r <= rdCnt_r + 4'h1;
    end

  chk_oe_high_gap: assert property ($rose(flashOeN) |=> flashOeN [*8] ##1 flashOeN [*6])
    else $error("Output enable high gap too short");
  chk_first_unjudged: assert property (resValid && pollAct_r && !resTimeout |-> rdCnt_r >= 4'h2)
    else $error("Poll finished on fewer than two reads");
  chk_poll_addr_fixed: assert property (pollAct_r && !flashOeN |-> flashAddr == addr_r)
    else $error("Poll address moved");
  chk_cmd_pins: assert property (cmdAct_r && !flashWeN |-> flashDoutEn && flashDout == data_r
    && flashAddr[ADDR_W-1:15] == '0 && flashAddr[14:0] == addr_r[14:0])
    else $error("Command byte or address wrong on pins");
  chk_poll_equal_pair: assert property (resValid && pollAct_r && !resTimeout |->
    togLast_r == togPrev_r && resData[TOGGLE_BIT] == togLast_r)
    else $error("Poll finished without two equal toggle reads");

  cov_poll_done: cover property (resValid && pollAct_r && !resTimeout);
  cov_poll_limit: cover property (resValid && pollAct_r && resTimeout);
  cov_cmd_write: cover property (cmdAct_r && $rose(flashWeN));
endmodule : fsl_host_assertions

bind fsl_host fsl_host_assertions #(.POLL_LIMIT_CYC(POLL_LIMIT_CYC)) chkHost (
  .clk_sys(clk_sys), .rst_n(rst_n), .opValid(opValid), .opReady(opReady), .opCode(opCode),
  .opAddr(opAddr), .opData(opData), .resValid(resValid), .resData(resData), .resTimeout(resTimeout),
  .flashAddr(flashAddr), .flashOeN(flashOeN), .flashWeN(flashWeN), .flashDout(flashDout),
  .flashDoutEn(flashDoutEn), .flashDin(flashDin));

/* File: verification/fsl_flash_model.sv */
// Behavioural byte-wide flash device seen from its pins.
`timescale 1ns/1ns
module fsl_flash_model
  import fsl_pkg::*;
#(
  parameter logic [14:0] CMD_A = 15'h5555,
  // Identification values are arbitrary.
  parameter logic [7:0] MAKER = 8'h5a,
  parameter logic [7:0] PART = 8'h3c
)
(
  // Supply and busy length from the bench
  input wire logic pwrOn,
  input wire logic [7:0] busyRds,
  // Flash pins
  input wire logic [ADDR_W-1:0] flashAddr,
  input wire logic flashCeN,
  input wire logic flashOeN,
  input wire logic flashWeN,
  input wire logic [DATA_W-1:0] dataBus,
  output logic [DATA_W-1:0] devData
);
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic idMode = 1'b0;
  logic lock = 1'b0;
  logic progNext = 1'b0;
  logic tog = 1'b0;
  logic [7:0] busy = 8'h0;
  logic [DATA_W-1:0] last = 8'h00;
  logic [DATA_W-1:0] rdv;
  wire rdEnd = flashOeN | flashCeN;
  wire wrEnd = flashWeN | flashCeN;

  always @*
    if (busy != 8'h0)
      rdv = {1'b0, tog, 6'h00};
    else if (idMode && flashAddr[17:1] == '0)
      rdv = flashAddr[0] ? PART : MAKER;
    else
      rdv = mem.exists(flashAddr) ? mem[flashAddr] : 8'hff;

  // A released bus shows the inverse of its last level, so a stale byte never reads as valid.
  assign devData = (rdEnd === 1'b0) ? rdv : ~last;

  always @(posedge rdEnd)
  begin
    last = rdv;
    if (busy != 8'h0)
    begin
      busy = busy - 8'h1;
      tog = ~tog;
    end
  end

  always @(posedge wrEnd)
    if (flashOeN === 1'b1 && pwrOn)
    begin
      if (progNext)
      begin
        progNext = 1'b0;
        if (!(lock && flashAddr <= 18'h01fff))
        begin
          mem[flashAddr] = dataBus;
          busy = busyRds;
        end
      end
      else if (flashAddr[14:0] == CMD_A)
        case (dataBus)
          8'h90: idMode = 1'b1;
          8'hf0: idMode = 1'b0;
          8'h40: lock = 1'b1;
          8'ha0: progNext = 1'b1;
          default: ;
        endcase
    end

  always @(negedge pwrOn)
  begin
    idMode = 1'b0;
    busy = 8'h0;
    progNext = 1'b0;
  end
endmodule : fsl_flash_model

/* File: verification/fsl_host_tb_top.sv */
// Self-checking bench: flash host controller against the behavioural device.
`timescale 1ns/1ns
module fsl_host_tb_top;
  import fsl_pkg::*;
  typedef struct {logic [7:0] d; logic [7:0] d2; logic to; logic bh; logic [2:0] m;} fsl_exp_t;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic opValid = 1'b0;
  logic [2:0] opCode = 3'h0;
  logic [ADDR_W-1:0] opAddr = '0;
  logic [DATA_W-1:0] opData = '0;
  logic opReady, resValid, resTimeout, resBootHit, flashCeN, flashOeN, flashWeN, flashDoutEn;
  logic [DATA_W-1:0] resData, resData2, flashDout, devData, dataBus;
  logic [ADDR_W-1:0] flashAddr, pa;
  logic [DATA_W-1:0] pd;
  logic pwrOn = 1'b1;
  logic [7:0] busyRds = 8'h3;
  int err_total = 0;
  int checks_done = 0;
  int seed = 32'h957bfefa;
  fsl_exp_t expQ[$];
  fsl_exp_t mon;

  assign dataBus = flashDoutEn ? flashDout : devData;

  fsl_host #(.POLL_LIMIT_CYC(2000)) DUT (.clk_sys(clk_sys), .rst_n(rst_n), .opValid(opValid),
    .opCode(opCode), .opAddr(opAddr), .opData(opData), .opReady(opReady), .resValid(resValid),
    .resData(resData), .resData2(resData2), .resTimeout(resTimeout), .resBootHit(resBootHit),
    .flashAddr(flashAddr), .flashCeN(flashCeN), .flashOeN(flashOeN), .flashWeN(flashWeN),
    .flashDout(flashDout), .flashDoutEn(flashDoutEn), .flashDin(dataBus));
  fsl_flash_model devModel (.pwrOn(pwrOn), .busyRds(busyRds), .flashAddr(flashAddr),
    .flashCeN(flashCeN), .flashOeN(flashOeN), .flashWeN(flashWeN), .dataBus(dataBus), .devData(devData));

  initial
    forever #5 clk_sys = ~clk_sys;

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic op(input logic [2:0] c, input logic [17:0] a, input logic [7:0] d, input logic [7:0] x,
    input logic [7:0] x2, input logic to, input logic bh, input logic [2:0] m);
    expQ.push_back('{x, x2, to, bh, m});
    @(posedge clk_sys);
    #1;
    while (opReady !== 1'b1)
    begin
      @(posedge clk_sys);
      #1;
    end
    opValid = 1'b1;
    opCode = c;
    opAddr = a;
    opData = d;
    @(posedge clk_sys);
    #1;
    opValid = 1'b0;
    repeat (3000)
      if (expQ.size() != 0)
        @(posedge clk_sys);
    // A result that never came is a mismatch; its note is dropped so later results stay aligned.
    check(8'(expQ.size()), 8'h00);
    expQ.delete();
  endtask : op

  task automatic cmd(input logic [7:0] d);
    op(OP_CMD, {3'($random(seed)), 15'h5555}, d, 0, 0, 0, 0, 3'b000);
  endtask : cmd

  task automatic prog(input logic [17:0] a, input logic [7:0] d, input logic [7:0] x);
    cmd(8'ha0);
    op(OP_WRITE, a, d, 0, 0, 0, a <= 18'h01fff, 3'b100);
    op(OP_POLL, a, 0, x, 0, 0, 0, 3'b001);
  endtask : prog

  always @(negedge clk_sys)
    if (resValid === 1'b1)
    begin
      check({7'h0, expQ.size() != 0}, 8'h01);
      mon = expQ.pop_front();
      if (mon.m[0])
        check(resData, mon.d);
      if (mon.m[1])
        check(resData2, mon.d2);
      if (mon.m[2])
        check({7'h0, resBootHit}, {7'h0, mon.bh});
      check({7'h0, resTimeout}, {7'h0, mon.to});
    end

  task automatic wrap_up();
    $display("Checks %0d, errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  initial
  begin
    repeat (40000) @(posedge clk_sys);
    err_total++;
    wrap_up();
  end

  initial
  begin
    repeat (16) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    pa = 18'h02000 | 18'($random(seed) & 32'hfff);
    pd = 8'($random(seed));
    op(OP_READ, pa, 0, 8'hff, 0, 0, 0, 3'b001);
    prog(pa, pd, pd);
    cmd(8'h90);
    op(OP_ID, '0, 0, 8'h5a, 8'h3c, 0, 0, 3'b011);
    cmd(8'hf0);
    op(OP_READ, pa, 0, pd, 0, 0, 0, 3'b001);
    // An undefined operation code falls back to a single array read.
    op(3'h6, pa, 0, pd, 0, 0, 0, 3'b101);
    cmd(8'h90);
    pwrOn = 1'b0;
    #20 pwrOn = 1'b1;
    op(OP_ID, '0, 0, 8'hff, 8'hff, 0, 0, 3'b011);
    cmd(8'h40);
    prog(18'h01fff, pd, 8'hff);
    prog(18'h02000, ~pd, ~pd);
    busyRds = 8'd100;
    cmd(8'ha0);
    op(OP_WRITE, pa, ~pd, 0, 0, 0, 0, 3'b100);
    op(OP_POLL, pa, 0, 0, 0, 1, 0, 3'b000);
    op(OP_POLL, pa, 0, ~pd, 0, 0, 0, 3'b001);
    for (int i = 0; i < 4; i++)
    begin
      busyRds = 8'($random(seed) & 32'h7);
      pd = 8'($random(seed));
      prog(18'h02000 | 18'($random(seed) & 32'h3fff), pd, pd);
    end
    wrap_up();
  end
endmodule : fsl_host_tb_top
